/* ctt_pkg.sv */
// shared constants and types for the column hit time tagger
package ctt_pkg;
  // ==========================================
  // time base
  localparam int REF_MHZ = 320;
  localparam int REF_PERIOD_PS = 3125;
  localparam int TAPS = 32;
  localparam int BIN_PS = REF_PERIOD_PS / TAPS;
  localparam int FINE_W = 5;
  localparam int COARSE_W = 8;
  localparam logic [FINE_W-1:0] PHASE_ALIGNED = 5'h00;
  localparam logic [FINE_W-1:0] PHASE_STEP = 5'h01;
  localparam logic [FINE_W-1:0] PHASE_FAST_STEP = 5'h02;
  // ==========================================
  // column organisation
  localparam int NPIX = 45;
  localparam int NGRP = 9;
  localparam int GSIZE = 5;
  localparam int NTEST = 9;
  localparam int GRP_W = 4;
  localparam int IDX_W = 3;
  // ==========================================
  // queue and serial stream
  localparam int FIFO_AW = 3;
  localparam int PTR_W = FIFO_AW + 1;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam int BITCNT_W = 5;

  typedef struct packed {
    logic [GRP_W-1:0] grp;
    logic [IDX_W-1:0] idx;
    logic edge_trail;
    logic [COARSE_W-1:0] coarse;
    logic [FINE_W-1:0] fine;
    logic masked;
  } ctt_word_t;

  localparam int WORD_W = $bits(ctt_word_t);
  localparam logic [BITCNT_W-1:0] LAST_BIT = 5'(WORD_W - 1);

  typedef enum logic [1:0] {SER_IDLE, SER_FETCH, SER_SHIFT} ctt_ser_state_t;
endpackage : ctt_pkg

/* ctt_tap_line.sv */
// delay tap line model: thermometer taps, coarse counter, phase lock loop
`timescale 1ns/1ps
module ctt_tap_line (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ref_mark_in,
  output logic [ctt_pkg::TAPS-1:0] taps_out,
  output logic [ctt_pkg::COARSE_W-1:0] coarse_out,
  output logic lock_out
);
  import ctt_pkg::*;

  logic [FINE_W-1:0] phase_q;
  logic [FINE_W-1:0] phase_d;
  logic [FINE_W-1:0] step;
  logic [TAPS-1:0] taps_d;
  logic aligned;

  // ==========================================
  // phase detector
  // phase correction on reference marker cycles only
  assign aligned = (phase_q == PHASE_ALIGNED);
  assign step = !ref_mark_in ? PHASE_STEP :
                aligned ? PHASE_STEP :
                phase_q[FINE_W-1] ? PHASE_FAST_STEP : PHASE_ALIGNED;
  assign phase_d = phase_q + step;

  genvar i;
  generate
    for (i = 0; i < TAPS; i++) begin : g_tap
      assign taps_d[i] = (FINE_W'(i) < phase_d);
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase_q <= PHASE_ALIGNED;
      taps_out <= '0;
      coarse_out <= '0;
      lock_out <= 1'b0;
    end else begin
      phase_q <= phase_d;
      taps_out <= taps_d;
      if (phase_d < phase_q) begin
        coarse_out <= coarse_out + 8'h01;
      end
      if (ref_mark_in) begin
        lock_out <= aligned;
      end
    end
  end
endmodule : ctt_tap_line

/* ctt_word_mem.sv */
// small queue memory with registered read data
`timescale 1ns/1ps
module ctt_word_mem (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [ctt_pkg::FIFO_AW-1:0] wr_addr_in,
  input wire ctt_pkg::ctt_word_t wr_data_in,
  input wire logic [ctt_pkg::FIFO_AW-1:0] rd_addr_in,
  output ctt_pkg::ctt_word_t rd_data_out
);
  import ctt_pkg::*;

  ctt_word_t mem_q [2**FIFO_AW];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule : ctt_word_mem

/* ctt_column_tagger.sv */
// column hit time tagger: group mergers, hit registers, queues, serializers
`timescale 1ns/1ps
module ctt_column_core #(
  parameter int PIX_USED = 45
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [ctt_pkg::NPIX-1:0] pix_hit_in,
  input wire logic [ctt_pkg::TAPS-1:0] taps_in,
  input wire logic [ctt_pkg::COARSE_W-1:0] coarse_in,
  input wire logic [ctt_pkg::NGRP-1:0] ser_en_in,
  output logic [ctt_pkg::NGRP-1:0] ser_clk_out,
  output logic [ctt_pkg::NGRP-1:0] ser_data_out,
  output logic [ctt_pkg::NGRP-1:0] ser_frame_out
);
  import ctt_pkg::*;

  // ==========================================
  // helpers
  // lowest set member; ties between pixels go to the lower index
  function automatic logic [IDX_W-1:0] first_set(input logic [GSIZE-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int k = GSIZE - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = IDX_W'(k);
      end
    end
    return r;
  endfunction : first_set

  // position of the single 1->0 step in the thermometer pattern
  function automatic logic [FINE_W-1:0] fine_code(input logic [TAPS-1:0] t);
    logic [FINE_W-1:0] r;
    r = '0;
    for (int k = 0; k < TAPS; k++) begin
      if (t[k]) begin
        r = FINE_W'(k + 1);
      end
    end
    return r;
  endfunction : fine_code

  // pixels beyond the populated count never fire
  logic [NPIX-1:0] pix_live;
  assign pix_live = pix_hit_in & NPIX'((46'h1 << PIX_USED) - 46'h1);

  genvar g, k;
  generate
    for (g = 0; g < NGRP; g++) begin : g_grp
      // ==========================================
      // group membership
      logic [GSIZE-1:0] hits;
      for (k = 0; k < GSIZE; k++) begin : g_mem
        assign hits[k] = pix_live[g + NGRP * k];
      end

      // ==========================================
      // group hit merger
      // five pixels share one merger
      logic [GSIZE-1:0] hits_prev_q;
      logic [GSIZE-1:0] rises;
      logic [GSIZE-1:0] losers;
      logic [IDX_W-1:0] owner_q;
      logic [IDX_W-1:0] owner_d;
      logic busy_q;
      logic busy_d;
      logic owner_ends;
      logic start;
      logic merged_prev_q;
      logic lead_trig;
      logic trail_trig;
      logic mask_trig;
      // masked rise held one cycle so its capture has the lead latency
      logic mask_seen_q;
      logic [IDX_W-1:0] mask_first_q;

      assign rises = hits & ~hits_prev_q;
      assign owner_ends = busy_q && !hits[owner_q];
      assign start = (!busy_q || owner_ends) && (|rises);
      assign owner_d = start ? first_set(rises) : owner_q;
      assign busy_d = start || (busy_q && !owner_ends);
      assign losers = start ? (rises & ~(GSIZE'(1) << owner_d)) : rises;
      assign mask_trig = |losers;
      assign lead_trig = busy_q && !merged_prev_q;
      assign trail_trig = !busy_q && merged_prev_q;

      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          hits_prev_q <= '0;
          owner_q <= '0;
          busy_q <= 1'b0;
          merged_prev_q <= 1'b0;
          mask_seen_q <= 1'b0;
          mask_first_q <= '0;
        end else begin
          hits_prev_q <= hits;
          owner_q <= owner_d;
          busy_q <= busy_d;
          merged_prev_q <= busy_q;
          mask_seen_q <= mask_trig;
          mask_first_q <= first_set(losers);
        end
      end

      // ==========================================
      // hit registers
      logic [TAPS-1:0] lead_taps_q;
      logic [TAPS-1:0] trail_taps_q;
      logic [COARSE_W-1:0] lead_coarse_q;
      logic [COARSE_W-1:0] trail_coarse_q;
      logic [IDX_W-1:0] lead_idx_q;
      logic [IDX_W-1:0] trail_idx_q;
      logic [TAPS-1:0] mask_taps_q;
      logic [COARSE_W-1:0] mask_coarse_q;
      logic [IDX_W-1:0] mask_idx_q;

      // shared tap bus to every register
      // one lead and one trail per group
      always_ff @(posedge clk_in) begin
        if (lead_trig) begin
          lead_taps_q <= taps_in;
          lead_coarse_q <= coarse_in;
          lead_idx_q <= owner_q;
        end
        if (trail_trig) begin
          trail_taps_q <= taps_in;
          trail_coarse_q <= coarse_in;
          trail_idx_q <= owner_q;
        end
        // masked pixel address kept
        // same two-cycle latency as lead keeps masked times comparable
        if (mask_seen_q) begin
          mask_taps_q <= taps_in;
          mask_coarse_q <= coarse_in;
          mask_idx_q <= mask_first_q;
        end
      end

      // ==========================================
      // word building and queue write
      logic lead_pend_q;
      logic trail_pend_q;
      logic mask_pend_q;
      logic wr_lead;
      logic wr_trail;
      logic wr_mask;
      logic wr_en;
      logic full;
      logic empty;
      logic [PTR_W-1:0] wr_ptr_q;
      logic [PTR_W-1:0] rd_ptr_q;
      logic rd_take;
      ctt_word_t wr_word;
      ctt_word_t rd_word;

      // a full queue holds the pending words back instead of dropping them
      assign full = (wr_ptr_q[FIFO_AW] != rd_ptr_q[FIFO_AW]) &&
                    (wr_ptr_q[FIFO_AW-1:0] == rd_ptr_q[FIFO_AW-1:0]);
      assign empty = (wr_ptr_q == rd_ptr_q);
      // leading before trailing keeps each pulse in order
      assign wr_lead = lead_pend_q && !full;
      assign wr_trail = trail_pend_q && !lead_pend_q && !full;
      assign wr_mask = mask_pend_q && !lead_pend_q && !trail_pend_q && !full;
      assign wr_en = wr_lead || wr_trail || wr_mask;

      assign wr_word.grp = GRP_W'(g);
      assign wr_word.idx = wr_lead ? lead_idx_q : wr_trail ? trail_idx_q : mask_idx_q;
      assign wr_word.edge_trail = wr_trail;
      assign wr_word.coarse = wr_lead ? lead_coarse_q :
                              wr_trail ? trail_coarse_q : mask_coarse_q;
      assign wr_word.fine = fine_code(wr_lead ? lead_taps_q :
                                      wr_trail ? trail_taps_q : mask_taps_q);
      assign wr_word.masked = wr_mask;

      // a fresh event in the write cycle keeps its pending flag set
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          lead_pend_q <= 1'b0;
          trail_pend_q <= 1'b0;
          mask_pend_q <= 1'b0;
          wr_ptr_q <= '0;
        end else begin
          lead_pend_q <= lead_trig || (lead_pend_q && !wr_lead);
          trail_pend_q <= trail_trig || (trail_pend_q && !wr_trail);
          mask_pend_q <= mask_seen_q || (mask_pend_q && !wr_mask);
          if (wr_en) begin
            wr_ptr_q <= wr_ptr_q + PTR_ONE;
          end
        end
      end

      ctt_word_mem u_mem (
        .clk_in(clk_in),
        .wr_en_in(wr_en),
        .wr_addr_in(wr_ptr_q[FIFO_AW-1:0]),
        .wr_data_in(wr_word),
        .rd_addr_in(rd_ptr_q[FIFO_AW-1:0]),
        .rd_data_out(rd_word)
      );

      // ==========================================
      // serializer
      ctt_ser_state_t state_q;
      ctt_ser_state_t state_d;
      logic [WORD_W-1:0] shreg_q;
      logic [BITCNT_W-1:0] bitcnt_q;
      logic last_bit;
      logic shift_now;

      assign rd_take = (state_q == SER_IDLE) && ser_en_in[g] && !empty;
      assign shift_now = (state_q == SER_SHIFT) && ser_en_in[g] && ser_clk_out[g];
      assign last_bit = (bitcnt_q == '0);

      always_comb begin
        state_d = state_q;
        case (state_q)
          SER_IDLE: begin
            if (rd_take) begin
              state_d = SER_FETCH;
            end
          end
          SER_FETCH: begin
            state_d = SER_SHIFT;
          end
          SER_SHIFT: begin
            if (shift_now && last_bit) begin
              state_d = SER_IDLE;
            end
          end
          default: begin
            state_d = SER_IDLE;
          end
        endcase
      end

      // independent stream per group
      // data changes on the falling edge of the stream clock, lsb first
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          state_q <= SER_IDLE;
          rd_ptr_q <= '0;
          shreg_q <= '0;
          bitcnt_q <= '0;
          ser_clk_out[g] <= 1'b0;
          ser_data_out[g] <= 1'b0;
          ser_frame_out[g] <= 1'b0;
        end else begin
          state_q <= state_d;
          if (rd_take) begin
            rd_ptr_q <= rd_ptr_q + PTR_ONE;
          end
          if (state_q == SER_FETCH) begin
            shreg_q <= rd_word;
            bitcnt_q <= LAST_BIT;
            ser_data_out[g] <= rd_word[0];
            ser_frame_out[g] <= 1'b1;
            ser_clk_out[g] <= 1'b0;
          end else if (state_q == SER_SHIFT && ser_en_in[g]) begin
            ser_clk_out[g] <= !ser_clk_out[g];
            if (shift_now && last_bit) begin
              ser_data_out[g] <= 1'b0;
              ser_frame_out[g] <= 1'b0;
            end else if (shift_now) begin
              shreg_q <= shreg_q >> 1;
              ser_data_out[g] <= shreg_q[1];
              bitcnt_q <= bitcnt_q - 5'h01;
            end
          end
        end
      end
    end
  endgenerate
endmodule : ctt_column_core

// ==========================================
// top: main column, test column, shared tap line
module ctt_column_tagger (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic REF_MARK_IN,
  input wire logic [ctt_pkg::NPIX-1:0] PIX_HIT_IN,
  input wire logic [ctt_pkg::NTEST-1:0] TEST_PIX_HIT_IN,
  input wire logic [ctt_pkg::NGRP-1:0] SER_EN_IN,
  input wire logic [ctt_pkg::NGRP-1:0] TEST_SER_EN_IN,
  output logic [ctt_pkg::NGRP-1:0] SER_CLK_OUT,
  output logic [ctt_pkg::NGRP-1:0] SER_DATA_OUT,
  output logic [ctt_pkg::NGRP-1:0] SER_FRAME_OUT,
  output logic [ctt_pkg::NGRP-1:0] TEST_SER_CLK_OUT,
  output logic [ctt_pkg::NGRP-1:0] TEST_SER_DATA_OUT,
  output logic [ctt_pkg::NGRP-1:0] TEST_SER_FRAME_OUT,
  output logic DLL_LOCK_OUT
);
  import ctt_pkg::*;

  logic [TAPS-1:0] taps;
  logic [COARSE_W-1:0] coarse;
  logic [NPIX-1:0] test_hits;

  // one line for the whole column
  ctt_tap_line u_taps (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .ref_mark_in(REF_MARK_IN),
    .taps_out(taps),
    .coarse_out(coarse),
    .lock_out(DLL_LOCK_OUT)
  );

  ctt_column_core #(.PIX_USED(NPIX)) u_main (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .pix_hit_in(PIX_HIT_IN),
    .taps_in(taps),
    .coarse_in(coarse),
    .ser_en_in(SER_EN_IN),
    .ser_clk_out(SER_CLK_OUT),
    .ser_data_out(SER_DATA_OUT),
    .ser_frame_out(SER_FRAME_OUT)
  );

  assign test_hits = NPIX'(TEST_PIX_HIT_IN);

  ctt_column_core #(.PIX_USED(NTEST)) u_test (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .pix_hit_in(test_hits),
    .taps_in(taps),
    .coarse_in(coarse),
    .ser_en_in(TEST_SER_EN_IN),
    .ser_clk_out(TEST_SER_CLK_OUT),
    .ser_data_out(TEST_SER_DATA_OUT),
    .ser_frame_out(TEST_SER_FRAME_OUT)
  );
endmodule : ctt_column_tagger

/* ctt_column_monitor.sv */
// assertions on the tagger serial streams and lock flag
`timescale 1ns/1ps
module ctt_column_monitor (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic REF_MARK_IN,
  input wire logic [ctt_pkg::NGRP-1:0] SER_EN_IN,
  input wire logic [ctt_pkg::NGRP-1:0] TEST_SER_EN_IN,
  input wire logic [ctt_pkg::NGRP-1:0] SER_CLK_OUT,
  input wire logic [ctt_pkg::NGRP-1:0] SER_DATA_OUT,
  input wire logic [ctt_pkg::NGRP-1:0] SER_FRAME_OUT,
  input wire logic [ctt_pkg::NGRP-1:0] TEST_SER_CLK_OUT,
  input wire logic [ctt_pkg::NGRP-1:0] TEST_SER_FRAME_OUT,
  input wire logic DLL_LOCK_OUT
);
  import ctt_pkg::*;
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  // ==========
  // bitwise over all streams of a column at once; gating and frame edge checks cover the main column streams only
  clk_in_frame_a: assert property (
    (SER_CLK_OUT & ~SER_FRAME_OUT) == '0) else $error("clock outside frame");
  test_clk_frame_a: assert property (
    (TEST_SER_CLK_OUT & ~TEST_SER_FRAME_OUT) == '0) else $error("test clock outside frame");
  clk_toggle_a: assert property (
    ($past(SER_EN_IN & SER_FRAME_OUT) & SER_FRAME_OUT & (SER_CLK_OUT ~^ $past(SER_CLK_OUT)))
    == '0) else $error("clock not toggling");
  test_toggle_a: assert property (
    ($past(TEST_SER_EN_IN & TEST_SER_FRAME_OUT) & TEST_SER_FRAME_OUT
    & (TEST_SER_CLK_OUT ~^ $past(TEST_SER_CLK_OUT))) == '0) else $error("test clock stuck");
  gate_clk_a: assert property (
    ((SER_CLK_OUT ^ $past(SER_CLK_OUT)) & ~$past(SER_EN_IN)) == '0)
    else $error("clock moved while gated");
  gate_data_a: assert property (
    ((SER_DATA_OUT ^ $past(SER_DATA_OUT)) & ~$past(SER_EN_IN) & $past(SER_FRAME_OUT)
    & SER_FRAME_OUT) == '0) else $error("data moved while gated");
  frame_start_a: assert property (
    (SER_FRAME_OUT & ~$past(SER_FRAME_OUT) & SER_CLK_OUT) == '0) else $error("frame opened high");
  frame_end_a: assert property (
    ($past(SER_FRAME_OUT) & ~SER_FRAME_OUT & (SER_DATA_OUT | ~$past(SER_CLK_OUT))) == '0)
    else $error("frame closed badly");
  lock_mark_a: assert property (
    $changed(DLL_LOCK_OUT) |-> $past(REF_MARK_IN)) else $error("lock moved without marker");
endmodule : ctt_column_monitor

/* ctt_readout_model.sv */
// readout side model: rebuilds serial time words per stream
`timescale 1ns/1ps
module ctt_readout_model (
  input wire logic clk_in,
  input wire logic [ctt_pkg::NGRP-1:0] ser_clk_in,
  input wire logic [ctt_pkg::NGRP-1:0] ser_data_in,
  input wire logic [ctt_pkg::NGRP-1:0] ser_frame_in
);
  import ctt_pkg::*;
  ctt_word_t rx_q[NGRP][$];
  logic [WORD_W-1:0] sh_q[NGRP];
  int cnt_q[NGRP] = '{default: 0};
  logic [NGRP-1:0] clk_q = '0;
  // ==========
  // deserialiser, one per stream
  always @(posedge clk_in) begin
    clk_q <= ser_clk_in;
    for (int g = 0; g < NGRP; g++) begin
      if (ser_clk_in[g] && !clk_q[g]) begin
        sh_q[g] <= {ser_data_in[g], sh_q[g][WORD_W-1:1]};
        cnt_q[g] <= cnt_q[g] + 1;
      end else if (!ser_frame_in[g] && cnt_q[g] != 0) begin
        // a short or long frame yields an unknown word
        rx_q[g].push_back(cnt_q[g] == WORD_W ? sh_q[g] : 'X);
        cnt_q[g] <= 0;
      end
    end
  end
endmodule : ctt_readout_model

/* ctt_column_tagger_test.sv */
// self-checking bench for the column hit time tagger
`timescale 1ns/1ps
module ctt_column_tagger_test;
  import ctt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mark = 1'b0;
  logic [NPIX-1:0] pix = '0;
  logic [NTEST-1:0] tpix = '0;
  logic [NGRP-1:0] en = '1;
  logic [NGRP-1:0] ten = '1;
  logic [NGRP-1:0] sclk, sdat, sfrm, tclk, tdat, tfrm;
  logic lock;
  int error_cnt = 0;
  int cmp_count = 0;

  ctt_column_tagger i_ctt_column_tagger (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .REF_MARK_IN(mark),
    .PIX_HIT_IN(pix), .TEST_PIX_HIT_IN(tpix), .SER_EN_IN(en), .TEST_SER_EN_IN(ten),
    .SER_CLK_OUT(sclk), .SER_DATA_OUT(sdat), .SER_FRAME_OUT(sfrm), .TEST_SER_CLK_OUT(tclk),
    .TEST_SER_DATA_OUT(tdat), .TEST_SER_FRAME_OUT(tfrm), .DLL_LOCK_OUT(lock));
  ctt_readout_model i_ctt_readout_model (.clk_in(clk), .ser_clk_in(sclk), .ser_data_in(sdat),
    .ser_frame_in(sfrm));
  ctt_readout_model i_ctt_readout_model_t (.clk_in(clk), .ser_clk_in(tclk),
    .ser_data_in(tdat), .ser_frame_in(tfrm));

  // ==========
  // shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic hit(input logic [NPIX-1:0] m, input int w);
    @(posedge clk);
    for (int i = 0; i < NPIX; i++) if (m[i]) pix[i] <= 1'b1;
    repeat (w) @(posedge clk);
    for (int i = 0; i < NPIX; i++) if (m[i]) pix[i] <= 1'b0;
  endtask : hit

  // waits a bounded time for the next word of a stream, then judges its fields
  task automatic want(input bit tst, input int g, input int idx, input bit tr, input bit mk,
                      output logic [12:0] t);
    ctt_word_t w;
    bit got;
    int n;
    w = 'X;
    got = 1'b0;
    for (n = 0; n < 400 && !got; n++) begin
      @(posedge clk);
      if (tst && i_ctt_readout_model_t.rx_q[g].size() > 0) begin
        w = i_ctt_readout_model_t.rx_q[g].pop_front();
        got = 1'b1;
      end
      if (!tst && i_ctt_readout_model.rx_q[g].size() > 0) begin
        w = i_ctt_readout_model.rx_q[g].pop_front();
        got = 1'b1;
      end
    end
    chk("group", 16'(g), 16'(w.grp));
    chk("pixel", 16'(idx), 16'(w.idx));
    chk("edge", 16'(tr), 16'(w.edge_trail));
    chk("masked", 16'(mk), 16'(w.masked));
    t = {w.coarse, w.fine};
  endtask : want

  // ==========
  // scenarios
  task automatic t_single;
    logic [12:0] tl, tt, dt;
    for (int p = 0; p < NPIX; p++) begin
      hit(NPIX'(1) << p, 1 + p % 7);
      want(1'b0, p % 9, p / 9, 1'b0, 1'b0, tl);
      want(1'b0, p % 9, p / 9, 1'b1, 1'b0, tt);
      dt = tt - tl;
      chk("width", 16'(1 + p % 7), 16'(dt));
    end
  endtask : t_single

  // two others of the group rise d cycles after the owner; d of 0 is a tie
  task automatic t_overlap(input int g, input int d, input int other);
    logic [12:0] tl, tm, tt, dt;
    fork
      hit(NPIX'(1) << g, 6);
      begin
        repeat (d) @(posedge clk);
        hit((NPIX'(1) << other) | (NPIX'(1) << (other + 18)), 2);
      end
    join
    want(1'b0, g, 0, 1'b0, 1'b0, tl);
    want(1'b0, g, other / 9, 1'b0, 1'b1, tm);
    want(1'b0, g, 0, 1'b1, 1'b0, tt);
    dt = tm - tl;
    chk("masked time", 16'(d), 16'(dt));
    dt = tt - tl;
    chk("owner width", 16'h6, 16'(dt));
  endtask : t_overlap

  // stream 2 held off while its words wait, then frozen mid-word
  task automatic t_gate;
    logic [12:0] tl, tt, dt;
    en[2] <= 1'b0;
    hit(NPIX'(1) << 11, 3);
    repeat (60) @(posedge clk);
    chk("held words", 16'h0, 16'(i_ctt_readout_model.rx_q[2].size()));
    en[2] <= 1'b1;
    repeat (15) @(posedge clk);
    en[2] <= 1'b0;
    repeat (30) @(posedge clk);
    chk("frozen frame", 16'h1, 16'(sfrm[2]));
    en[2] <= 1'b1;
    want(1'b0, 2, 1, 1'b0, 1'b0, tl);
    want(1'b0, 2, 1, 1'b1, 1'b0, tt);
    dt = tt - tl;
    chk("gated width", 16'h3, 16'(dt));
  endtask : t_gate

  // every group of both columns hit at once
  task automatic t_columns;
    logic [12:0] t0, tl, tt;
    fork
      hit(NPIX'(9'h1FF) << 9, 4);
      begin
        @(posedge clk);
        tpix <= '1;
        repeat (4) @(posedge clk);
        tpix <= '0;
      end
    join
    for (int g = 0; g < NGRP; g++) begin
      want(1'b0, g, 1, 1'b0, 1'b0, tl);
      if (g == 0) t0 = tl;
      chk("group lead", 16'(t0), 16'(tl));
      want(1'b1, g, 0, 1'b0, 1'b0, tt);
      chk("test lead", 16'(t0), 16'(tt));
      want(1'b0, g, 1, 1'b1, 1'b0, tt);
      want(1'b1, g, 0, 1'b1, 1'b0, tt);
    end
  endtask : t_columns

  task automatic mark_at(input int per);
    @(posedge clk);
    mark <= 1'b1;
    @(posedge clk);
    mark <= 1'b0;
    repeat (per - 2) @(posedge clk);
  endtask : mark_at

  // ideal-period markers pull the phase in; one short period must drop lock
  task automatic t_lock;
    int n;
    for (n = 0; n < 40 && lock !== 1'b1; n++) mark_at(32);
    chk("lock", 16'h1, 16'(lock));
    repeat (4) mark_at(32);
    chk("lock kept", 16'h1, 16'(lock));
    mark_at(31);
    mark_at(32);
    chk("lock lost", 16'h0, 16'(lock));
    mark_at(32);
    chk("lock regained", 16'h1, 16'(lock));
  endtask : t_lock

  task print_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset outputs", 16'h0, 16'({sfrm, lock}));
    t_single();
    t_overlap(4, 2, 13);
    t_overlap(7, 0, 25);
    t_gate();
    t_columns();
    t_lock();
    print_verdict();
  end

  // about seven times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule : ctt_column_tagger_test

bind ctt_column_tagger ctt_column_monitor i_ctt_column_monitor (.CLOCK_IN, .RESET_N_IN,
  .REF_MARK_IN, .SER_EN_IN, .TEST_SER_EN_IN, .SER_CLK_OUT, .SER_DATA_OUT, .SER_FRAME_OUT,
  .TEST_SER_CLK_OUT, .TEST_SER_FRAME_OUT, .DLL_LOCK_OUT);
